// [hdl/scm_pkg.sv]
/*
  Package for the system clock and power-mode controller: register map, field positions,
  reset values, states and timing constants.
  Assumes a 32-bit APB register bus and a 20 MHz control clock.
*/
package scm_pkg;

  localparam logic [7:0] SYS_CLK_CTRL_OFFSET  = 8'h00;
  localparam logic [7:0] FAST_OSC_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] PWR_STATUS_OFFSET    = 8'h08;
  localparam logic [7:0] WAKE_CTRL_OFFSET     = 8'h0c;

  localparam int SEL_MSB        = 7;
  localparam int SEL_LSB        = 5;
  localparam int FAST_KEEP_BIT  = 1;
  localparam int SLOW_KEEP_BIT  = 0;
  localparam int STABLE_BIT     = 1;
  localparam int ENABLE_BIT     = 0;

  localparam logic [7:0] SYS_CLK_CTRL_RESET  = 8'h00;
  localparam logic [7:0] FAST_OSC_CTRL_RESET = 8'h01;
  localparam logic [2:0] SEL_SUB             = 3'h7;

  // Clock rates and oscillator start-up times.
  localparam int MCLK_HZ          = 20000000;
  localparam int FAST_OSC_HZ      = 8000000;
  localparam int FAST_START_NS    = 16000;
  localparam int SLOW_START_NS    = 2000;
  localparam int FAST_START_CYC   = (FAST_START_NS * (MCLK_HZ / 1000000) + 999) / 1000;
  localparam int SLOW_START_CYC   = (SLOW_START_NS * (MCLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_DELAY_CYC   = 2;

  typedef enum logic [1:0] {
    SCM_RUN    = 2'b00,
    SCM_HALTED = 2'b01,
    SCM_WAKE   = 2'b11
  } scm_state_e;

  typedef enum logic [1:0] {
    SCM_SLEEP           = 2'b00,
    SCM_HALT_SUB_ONLY   = 2'b01,
    SCM_HALT_BOTH       = 2'b11,
    SCM_HALT_FAST_ONLY  = 2'b10
  } scm_halt_e;

  typedef struct packed {
    logic fastOscOn;
    logic slowOscOn;
    logic sysClkOn;
    logic subClkOn;
  } scm_clk_s;

  typedef struct packed {
    logic resumeNext;
    logic takeIrq;
    logic resetPcSp;
  } scm_resume_s;

endpackage

// [hdl/scm_sysclk_mode_power_control.sv]
/*
  System clock selection and power-mode controller with an APB register slave.
  Assumes the CPU core gives one-cycle halt and clear-watchdog pulses, and that the fast
  clock and sub-clock enters as ticks on the control clock.
*/
// Notes on behaviour
// - Select code 0..6 picks fast clock divided by 1..64; 7 picks sub-clock.
// - Fast keep bit chooses fast oscillator on or off while halted.
// - Slow keep bit chooses slow oscillator on or off while halted; an enabled watchdog also keeps it on.
// - Disabling the fast oscillator clears stable flag; enabling it sets the flag once stable.
// - Fast oscillator enable bit turns it on or off; resets to one.
// - Unimplemented control bits read as zero.
// - Select 7 moves to sub-clock only after the slow oscillator is stable.
// - Select 0..6 from slow returns to fast; software watches stable flag.
// - Halt with both keep bits low enters sleep: system clock stops.
// - Halt with fast keep low, slow keep high keeps only the sub-clock.
// - Halt with both keep bits high keeps both clocks running.
// - Halt with fast keep high, slow keep low keeps only the fast clock.
// - Halt entry sets power-down flag and clears watchdog timeout flag.
// - Halt entry clears watchdog counter; it runs on only if enabled.
// - Wake on enabled port A falling edge, interrupt or watchdog overflow.
// - Power-down flag clears only on power-up or clear-watchdog instruction.
// - Watchdog overflow while halted sets timeout and resets only PC and SP.
// - Port A wake resumes after the halt instruction.
// - Disabled or stack-full interrupt wake resumes; interrupt stays pending.
// - Enabled interrupt with free stack gets normal interrupt response.
// - Interrupt already pending at halt does not wake that halt.
// - Fast oscillator runs at a nominal 8 MHz.
// - In sleep the watchdog slow clock runs only when the watchdog is enabled.
`timescale 1ns/1ps
module scm_sysclk_mode_power_control #(
  parameter int PORTA_WIDTH = 8
) (
  // Clock and reset.
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // CPU core.
  input  wire logic                     haltReq,
  input  wire logic                     clrWdtReq,
  input  wire logic                     wdtEnabled,
  input  wire logic                     wdtOverflow,
  input  wire logic                     irqRequest,
  input  wire logic                     irqEnabled,
  input  wire logic                     stackFull,
  input  wire logic [PORTA_WIDTH-1:0]   portaPin,
  output logic                          cpuHold,
  output scm_pkg::scm_resume_s          resume,
  output logic                          wdtClear,
  output logic                          powerDownFlag,
  output logic                          watchdogTimeoutFlag,
  // Clock outputs, as enables on the control clock.
  output scm_pkg::scm_clk_s             clkOn,
  output logic                          sysClkTick,
  output logic                          wdtClkOn
);
  import scm_pkg::*;

  initial begin
    if (PORTA_WIDTH < 1 || PORTA_WIDTH > 8) begin
      $error("PORTA_WIDTH must be 1 to 8");
    end
  end

  // Register state.
  logic [2:0]             sysclkSelect;
  logic                   fastOscHaltKeep;
  logic                   slowOscHaltKeep;
  logic                   fastOscEnable;
  logic                   fastOscStable;
  logic [PORTA_WIDTH-1:0] portaWakeEnable;
  logic                   subActive;
  logic                   slowStable;
  scm_state_e             state;
  scm_halt_e              haltMode;
  logic                   irqMaskedAtHalt;
  logic [9:0]             fastCnt;
  logic [9:0]             slowCnt;
  logic [5:0]             divCnt;
  logic [2:0]             subCnt;
  logic [PORTA_WIDTH-1:0] pinS1;
  logic [PORTA_WIDTH-1:0] pinS2;
  logic [PORTA_WIDTH-1:0] pinS3;
  logic [PORTA_WIDTH-1:0] pinLevel;

  logic setup;
  logic wrEn;
  logic fastRun;
  logic slowRun;
  logic portaFall;
  logic irqWake;
  logic anyWake;

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign setup   = psel && !penable;
  assign wrEn    = psel && penable && pwrite;
  // Fast oscillator runs if enabled, in run state or with keep set; slow in run state, with keep set or watchdog enabled.
  assign fastRun = fastOscEnable && (state == SCM_RUN || fastOscHaltKeep);
  assign slowRun = state == SCM_RUN || slowOscHaltKeep || wdtEnabled;

  // APB: answer at the access phase with no wait state.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(isAddr(paddr, SYS_CLK_CTRL_OFFSET) ||
                 isAddr(paddr, FAST_OSC_CTRL_OFFSET) || isAddr(paddr, PWR_STATUS_OFFSET) ||
                 isAddr(paddr, WAKE_CTRL_OFFSET));
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        if (isAddr(paddr, SYS_CLK_CTRL_OFFSET)) begin
          prdata <= {24'h0, sysclkSelect, 3'h0, fastOscHaltKeep, slowOscHaltKeep};
        end else if (isAddr(paddr, FAST_OSC_CTRL_OFFSET)) begin
          prdata <= {30'h0, fastOscStable, fastOscEnable};
        end else if (isAddr(paddr, PWR_STATUS_OFFSET)) begin
          prdata <= {28'h0, subActive, slowStable, watchdogTimeoutFlag, powerDownFlag};
        end else if (isAddr(paddr, WAKE_CTRL_OFFSET)) begin
          prdata <= {{(32-PORTA_WIDTH){1'b0}}, portaWakeEnable};
        end
      end
    end
  end

  // Control register writes take effect at the completing access edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sysclkSelect    <= SYS_CLK_CTRL_RESET[SEL_MSB:SEL_LSB];
      fastOscHaltKeep <= SYS_CLK_CTRL_RESET[FAST_KEEP_BIT];
      slowOscHaltKeep <= SYS_CLK_CTRL_RESET[SLOW_KEEP_BIT];
      fastOscEnable   <= FAST_OSC_CTRL_RESET[ENABLE_BIT];
      portaWakeEnable <= '0;
    end else if (wrEn && pready) begin
      if (isAddr(paddr, SYS_CLK_CTRL_OFFSET)) begin
        sysclkSelect    <= pwdata[SEL_MSB:SEL_LSB];
        fastOscHaltKeep <= pwdata[FAST_KEEP_BIT];
        slowOscHaltKeep <= pwdata[SLOW_KEEP_BIT];
      end else if (isAddr(paddr, FAST_OSC_CTRL_OFFSET)) begin
        fastOscEnable <= pwdata[ENABLE_BIT];
      end else if (isAddr(paddr, WAKE_CTRL_OFFSET)) begin
        portaWakeEnable <= pwdata[PORTA_WIDTH-1:0];
      end
    end
  end

  // Fast oscillator start-up: stable flag drops while it restarts.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fastCnt       <= 10'h0;
      fastOscStable <= 1'b0;
    end else if (!fastRun) begin
      fastCnt       <= 10'h0;
      fastOscStable <= 1'b0;
    end else if (fastCnt < 10'(FAST_START_CYC)) begin
      fastCnt       <= fastCnt + 10'h1;
      fastOscStable <= 1'b0;
    end else begin
      fastOscStable <= 1'b1;
    end
  end

  // Slow oscillator start-up.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slowCnt    <= 10'h0;
      slowStable <= 1'b0;
    end else if (!slowRun) begin
      slowCnt    <= 10'h0;
      slowStable <= 1'b0;
    end else if (slowCnt < 10'(SLOW_START_CYC)) begin
      slowCnt    <= slowCnt + 10'h1;
      slowStable <= 1'b0;
    end else begin
      slowStable <= 1'b1;
    end
  end

  // Source switch happens only at a divider wrap, so no pulse is cut short.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      subActive <= 1'b0;
    end else if (sysclkSelect == SEL_SUB && !subActive && slowStable && divCnt == 6'h0) begin
      subActive <= 1'b1;
    end else if (sysclkSelect != SEL_SUB && subActive && fastOscStable && subCnt == 3'h0) begin
      subActive <= 1'b0;
    end
  end

  // Divider chain for the fast clock, and a sub-clock tick generator.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt     <= 6'h0;
      subCnt     <= 3'h0;
      sysClkTick <= 1'b0;
    end else begin
      divCnt     <= fastOscStable ? divCnt + 6'h1 : 6'h0;
      subCnt     <= slowStable ? subCnt + 3'h1 : 3'h0;
      sysClkTick <= 1'b0;
      if (state == SCM_RUN || state == SCM_WAKE) begin
        if (subActive) begin
          sysClkTick <= slowStable && subCnt == 3'h0;
        end else begin
          sysClkTick <= fastOscStable &&
                        ((divCnt & ((6'h1 << sysclkSelect) - 6'h1)) == 6'h0);
        end
      end
    end
  end

  // Port A pins pass a three-stage synchroniser; stages two and three must agree.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1    <= '1;
      pinS2    <= '1;
      pinS3    <= '1;
      pinLevel <= '1;
    end else begin
      pinS1 <= portaPin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      for (int i = 0; i < PORTA_WIDTH; i++) begin
        if (pinS2[i] == pinS3[i]) begin
          pinLevel[i] <= pinS3[i];
        end
      end
    end
  end

  assign portaFall = |(pinLevel & ~pinS3 & ~pinS2 & portaWakeEnable);
  assign irqWake   = irqRequest && !irqMaskedAtHalt;
  assign anyWake   = portaFall || irqWake || wdtOverflow;

  // Halt sequencing and wake-up.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= SCM_RUN;
      haltMode        <= SCM_SLEEP;
      irqMaskedAtHalt <= 1'b0;
      resume          <= '0;
      cpuHold         <= 1'b0;
      wdtClear        <= 1'b0;
    end else begin
      resume   <= '0;
      wdtClear <= 1'b0;
      case (state)
        SCM_RUN: begin
          if (haltReq) begin
            state           <= SCM_HALTED;
            haltMode        <= scm_halt_e'({fastOscHaltKeep, slowOscHaltKeep});
            irqMaskedAtHalt <= irqRequest;
            cpuHold         <= 1'b1;
            wdtClear        <= 1'b1;
          end
        end
        SCM_HALTED: begin
          if (anyWake) begin
            state <= SCM_WAKE;
            if (wdtOverflow) begin
              resume.resetPcSp <= 1'b1;
            end else if (portaFall || !irqEnabled || stackFull) begin
              resume.resumeNext <= 1'b1;
            end else begin
              resume.takeIrq <= 1'b1;
            end
          end
        end
        SCM_WAKE: begin
          state           <= SCM_RUN;
          cpuHold         <= 1'b0;
          irqMaskedAtHalt <= 1'b0;
        end
        default: begin
          state <= SCM_RUN;
        end
      endcase
    end
  end

  // Status flags: a set and a clear in one cycle leave the flag set.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      powerDownFlag       <= 1'b0;
      watchdogTimeoutFlag <= 1'b0;
    end else begin
      if (state == SCM_RUN && haltReq) begin
        powerDownFlag       <= 1'b1;
        watchdogTimeoutFlag <= 1'b0;
      end else begin
        if (clrWdtReq) begin
          powerDownFlag <= 1'b0;
        end
        if (state == SCM_HALTED && wdtOverflow) begin
          watchdogTimeoutFlag <= 1'b1;
        end
      end
    end
  end

  // Clock gating outputs.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clkOn    <= '0;
      wdtClkOn <= 1'b0;
    end else begin
      clkOn.fastOscOn <= fastRun;
      clkOn.slowOscOn <= slowRun;
      clkOn.sysClkOn  <= state != SCM_HALTED;
      clkOn.subClkOn  <= state != SCM_HALTED ||
                         haltMode == SCM_HALT_SUB_ONLY || haltMode == SCM_HALT_BOTH;
      wdtClkOn        <= slowRun && wdtEnabled;
    end
  end

  property p_halt_flags;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_RUN && haltReq) |=> powerDownFlag && !watchdogTimeoutFlag && cpuHold;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_wdt_clear;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_RUN && haltReq) |=> wdtClear ##1 !wdtClear;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

  property p_sleep_clk;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_HALTED && haltMode == SCM_SLEEP) |=> !clkOn.sysClkOn && !clkOn.subClkOn;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");

  property p_pdf_hold;
    @(posedge mclk) disable iff (sys_rst)
    ($past(powerDownFlag) && !powerDownFlag) |-> $past(clrWdtReq);
  endproperty
  a_pdf_hold: assert property (p_pdf_hold) else $error("power-down flag cleared wrongly");

  property p_wdt_wake;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_HALTED && wdtOverflow) |=> watchdogTimeoutFlag && resume.resetPcSp;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_irq_resp;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_HALTED && irqWake && !portaFall && !wdtOverflow && irqEnabled && !stackFull)
      |=> resume.takeIrq;
  endproperty
  a_irq_resp: assert property (p_irq_resp) else $error("interrupt response missing");

  property p_pending_irq;
    @(posedge mclk) disable iff (sys_rst)
    (state == SCM_HALTED && irqMaskedAtHalt && !portaFall && !wdtOverflow) |=> state == SCM_HALTED;
  endproperty
  a_pending_irq: assert property (p_pending_irq) else $error("pending interrupt woke");

  property p_fast_stable;
    @(posedge mclk) disable iff (sys_rst)
    $rose(fastRun) |=> !fastOscStable [*8];
  endproperty
  a_fast_stable: assert property (p_fast_stable) else $error("stable flag too early");

  property p_sub_switch;
    @(posedge mclk) disable iff (sys_rst)
    $rose(subActive) |-> $past(slowStable) && $past(divCnt) == 6'h0;
  endproperty
  a_sub_switch: assert property (p_sub_switch) else $error("unsafe switch to sub-clock");

endmodule

// [bench/scm_cpu_model.sv]
/*
  CPU core model that issues halt and clear-watchdog instructions as one-cycle pulses.
  Assumes the controller samples both requests on the rising edge of mclk.
*/
`timescale 1ns/1ps
module scm_cpu_model (
  // Clock.
  input  wire logic mclk,
  // Controller side.
  input  wire logic cpuHold,
  output logic      haltReq,
  output logic      clrWdtReq
);
  initial begin
    haltReq   = 1'b0;
    clrWdtReq = 1'b0;
  end

  // A held core executes nothing, so a halt is only issued while it runs.
  task automatic halt();
    @(posedge mclk);
    if (cpuHold !== 1'b1) begin
      haltReq <= 1'b1;
    end
    @(posedge mclk);
    haltReq <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic clearWdt();
    @(posedge mclk);
    clrWdtReq <= 1'b1;
    @(posedge mclk);
    clrWdtReq <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// [bench/tb_sysclk_mode_power_control.sv]
/*
  Self-checking testbench for the clock and power-mode controller.
  Assumes the design answers APB in the access phase and the core model drives halts.
*/
`timescale 1ns/1ps
module tb_sysclk_mode_power_control;
  import scm_pkg::*;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, portaPin;
  logic [31:0] pwdata, prdata, rdata, rnd;
  logic        haltReq, clrWdtReq, wdtEnabled, wdtOverflow, irqRequest, irqEnabled;
  logic        stackFull, cpuHold, wdtClear, powerDownFlag, watchdogTimeoutFlag;
  logic        sysClkTick, wdtClkOn;
  logic [2:0]  b;
  scm_resume_s resume, rs;
  scm_clk_s    clkOn;
  int          failures, samples_checked, n, modelPdf, modelTo;
  int          expQ[$];

  scm_sysclk_mode_power_control DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .haltReq(haltReq), .clrWdtReq(clrWdtReq),
    .wdtEnabled(wdtEnabled), .wdtOverflow(wdtOverflow), .irqRequest(irqRequest),
    .irqEnabled(irqEnabled), .stackFull(stackFull), .portaPin(portaPin), .cpuHold(cpuHold),
    .resume(resume), .wdtClear(wdtClear), .powerDownFlag(powerDownFlag),
    .watchdogTimeoutFlag(watchdogTimeoutFlag), .clkOn(clkOn), .sysClkTick(sysClkTick),
    .wdtClkOn(wdtClkOn));
  scm_cpu_model cpu (.mclk(mclk), .cpuHold(cpuHold), .haltReq(haltReq), .clrWdtReq(clrWdtReq));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected resume code per wake source: watchdog, port A, served irq, pending irq.
  function automatic logic [31:0] expWake(input int k);
    return (k == 0) ? 32'h1 : ((k == 2) ? 32'h2 : 32'h4);
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task timeout();
    failures++;
    tally_and_finish();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout();
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tickGap();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sysClkTick !== 1'b1 && n < 3000);
    if (sysClkTick !== 1'b1) timeout();
  endtask

  task automatic pollStable();
    int k;
    k = 0;
    do begin
      apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
      k++;
    end while (rdata[STABLE_BIT] !== 1'b1 && k < 300);
    if (rdata[STABLE_BIT] !== 1'b1) timeout();
    chk(rdata, 32'h3);
  endtask

  task automatic waitResume();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (resume === 3'h0 && k < 100);
    if (resume === 3'h0) timeout();
    rs = resume;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    timeout();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, wdtOverflow, irqRequest, irqEnabled, stackFull} = 7'h0;
    {paddr, pwdata, wdtEnabled} = 41'h0;
    portaPin = 8'hff;
    failures = 0;
    samples_checked = 0;
    modelPdf = 0;
    modelTo = 0;
    rnd = 32'h094d;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, SYS_CLK_CTRL_OFFSET, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk(rdata, 32'h1);
    pollStable();
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(rdata, 32'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      apb(1'b1, SYS_CLK_CTRL_OFFSET, rnd);
      apb(1'b0, SYS_CLK_CTRL_OFFSET, 32'h0);
      chk(rdata, {24'h0, rnd[7:0] & 8'he3});
      apb(1'b1, FAST_OSC_CTRL_OFFSET, rnd | 32'h1);
      apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
      chk(rdata & 32'hfffffffd, 32'h1);
    end
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, SYS_CLK_CTRL_OFFSET, 32'(s) << SEL_LSB);
      repeat (4) tickGap();
      chk(32'(n), (s == 7) ? 32'h8 : (32'h1 << s));
    end
    apb(1'b1, FAST_OSC_CTRL_OFFSET, 32'h0);
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk(rdata, 32'h0);
    repeat (4) @(posedge mclk);
    chk({31'h0, clkOn.fastOscOn}, 32'h0);
    apb(1'b1, FAST_OSC_CTRL_OFFSET, 32'h1);
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk(rdata, 32'h1);
    pollStable();
    apb(1'b1, SYS_CLK_CTRL_OFFSET, 32'h0);
    repeat (3) tickGap();
    chk(32'(n), 32'h1);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      b = rnd[3:1];
      wdtEnabled <= rnd[0];
      irqRequest <= (k == 1);
      irqEnabled <= (k == 2);
      stackFull  <= (k == 3);
      apb(1'b1, SYS_CLK_CTRL_OFFSET, 32'(k));
      apb(1'b1, WAKE_CTRL_OFFSET, 32'h1 << b);
      cpu.halt();
      modelPdf = 1;
      modelTo = 0;
      chk({31'h0, wdtClear}, 32'h1);
      chk({31'h0, cpuHold}, 32'h1);
      chk({31'h0, powerDownFlag}, 32'(modelPdf));
      chk({31'h0, watchdogTimeoutFlag}, 32'(modelTo));
      repeat (4) @(posedge mclk);
      chk({31'h0, wdtClear}, 32'h0);
      chk({31'h0, clkOn.fastOscOn}, 32'(k >> 1));
      chk({31'h0, clkOn.subClkOn}, 32'(k & 1));
      chk({31'h0, clkOn.slowOscOn}, 32'((k & 1) | wdtEnabled));
      if (k == 0) begin
        chk({31'h0, clkOn.sysClkOn}, 32'h0);
        chk({31'h0, wdtClkOn}, {31'h0, wdtEnabled});
      end
      repeat (20) @(posedge mclk);
      chk({31'h0, cpuHold}, 32'h1);
      expQ.push_back(expWake(k));
      if (k == 0) begin
        wdtOverflow <= 1'b1;
        modelTo = 1;
      end else if (k == 1) begin
        portaPin[b] <= 1'b0;
      end else begin
        irqRequest <= 1'b1;
      end
      @(posedge mclk);
      wdtOverflow <= 1'b0;
      waitResume();
      irqRequest <= 1'b0;
      portaPin   <= 8'hff;
      chk({29'h0, rs}, expQ.pop_front());
      repeat (2) @(posedge mclk);
      chk({31'h0, cpuHold}, 32'h0);
      chk({31'h0, watchdogTimeoutFlag}, 32'(modelTo));
      chk({31'h0, powerDownFlag}, 32'(modelPdf));
    end
    cpu.clearWdt();
    modelPdf = 0;
    chk({31'h0, powerDownFlag}, 32'(modelPdf));
    apb(1'b0, PWR_STATUS_OFFSET, 32'h0);
    chk(rdata & 32'h3, {30'h0, 1'(modelTo), 1'(modelPdf)});
    tally_and_finish();
  end
endmodule
